// File: hw/seq_ctrl_pkg.sv
// Constants, field layouts and carrier types for the sample sequencer control block.
// Assumes a 32-bit classic Wishbone register bus and a single 25 MHz clock.
package seq_ctrl_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_SEQ      = 4;
  localparam int MAX_DEPTH    = 8;
  localparam int RESULT_W     = 10;
  localparam int ACC_W        = 16;
  localparam int AVG_MAX_LOG2 = 6;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_ENABLE   = 12'h000;
  localparam logic [11:0] OFF_RAW_INT  = 12'h004;
  localparam logic [11:0] OFF_INT_MASK = 12'h008;
  localparam logic [11:0] OFF_MASK_CLR = 12'h00c;
  localparam logic [11:0] OFF_OVERFLOW = 12'h010;
  localparam logic [11:0] OFF_TRIG_SEL = 12'h014;
  localparam logic [11:0] OFF_UNDERFLW = 12'h018;
  localparam logic [11:0] OFF_PRIORITY = 12'h020;
  localparam logic [11:0] OFF_SW_START = 12'h028;
  localparam logic [11:0] OFF_AVG_CTRL = 12'h030;
  localparam logic [11:0] OFF_SEQ_BASE = 12'h040;
  localparam logic [2:0]  SEQ_BLK_LO   = 3'h2;
  localparam logic [2:0]  SEQ_BLK_HI   = 3'h5;
  localparam logic [4:0]  SUB_INPUT    = 5'h00;
  localparam logic [4:0]  SUB_FLAGS    = 5'h04;
  localparam logic [4:0]  SUB_FIFO     = 5'h08;
  localparam logic [4:0]  SUB_STATUS   = 5'h0c;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [15:0] PRIORITY_RST = 16'h3210;
  localparam logic [2:0]  AVG_RST      = 3'h0;
  localparam int FLAG_DIFF   = 0;
  localparam int FLAG_END    = 1;
  localparam int FLAG_IE     = 2;
  localparam int FLAG_TEMP   = 3;
  localparam int FST_TAIL    = 0;
  localparam int FST_HEAD    = 4;
  localparam int FST_EMPTY   = 8;
  localparam int FST_FULL    = 12;

  // ----------------------------------------------------------------
  // Trigger source codes
  // ----------------------------------------------------------------
  localparam logic [3:0] TRIG_SOFTWARE = 4'h0;
  localparam logic [3:0] TRIG_COMPARE  = 4'h1;
  localparam logic [3:0] TRIG_TIMER    = 4'h2;
  localparam logic [3:0] TRIG_PWM      = 4'h3;
  localparam logic [3:0] TRIG_GPIO     = 4'h4;
  localparam logic [3:0] TRIG_ALWAYS   = 4'h5;

  // ----------------------------------------------------------------
  // Converter clock targets in kHz
  // ----------------------------------------------------------------
  localparam int CONV_CLK_MAX_KHZ    = 18000;
  localparam int CONV_CLK_TARGET_KHZ = 16667;

  typedef struct packed {
    logic       temp;
    logic       diff;
    logic [3:0] input_sel;
  } conv_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_WAIT = 2'b10
  } seq_state_t;

endpackage

// File: hw/seq_ctrl.sv
// Control logic of a four-sequencer converter front end with per-sequencer result FIFOs.
// Assumes a classic Wishbone master, a converter core that answers each start with one
// done pulse and a 10-bit result, and trigger inputs synchronous to clk_i.
//
// What this block does
// - Four sequencers of 8, 4, 4 and 1 steps with matching FIFO depths.
// - FIFO words are 32 bits with the result in bits 9:0.
// - Each step has an input nibble and a flag nibble.
// - The same input may appear in several steps and is converted each time.
// - A step with its interrupt flag set raises the raw interrupt when done.
// - A sequence stops after the step carrying the end flag.
// - Result FIFOs are circular; reading the result address pops the oldest entry.
// - Head, tail, full and empty of each FIFO are readable.
// - Push into full FIFO sets overflow; read of empty sets underflow.
// - Converter clock divider is the smallest divisor of the source clock keeping the converter clock at or below 18 MHz.
// - A sequencer interrupt leaves the block only when its mask bit is set.
// - Masked status reads as raw status AND mask.
// - Writing one to a masked status bit clears it; zero does nothing.
// - Concurrent triggers are served by priority value, zero highest.
// - Each sequencer selects its own trigger source, including continuous.
// - Writing one to a software start bit starts that software-triggered sequencer.
// - Averaging accumulates up to 64 conversions into one FIFO entry.
// - Averaging is off after reset; results pass unchanged.
// - One averaging stage with one count serves all sequencers and modes.
// - Reset priorities make the first sequencer highest, the fourth lowest.
//
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/1ps

module seq_ctrl (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic [11:0]               wb_adr_i,
  input  wire logic [31:0]               wb_dat_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic                      wb_we_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  input  wire logic                      trig_timer_i,
  input  wire logic                      trig_comp_i,
  input  wire logic                      trig_pwm_i,
  input  wire logic                      trig_gpio_i,
  output logic                           conv_start_o,
  output seq_ctrl_pkg::conv_cmd_t        conv_cmd_o,
  input  wire logic                      conv_done_i,
  input  wire logic [9:0]                conv_data_i,
  input  wire logic [7:0]                src_mhz_i,
  output logic      [3:0]                conv_div_o,
  output logic      [3:0]                irq_o
);
  import seq_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] depth_of(input logic [1:0] n);
    unique case (n)
      2'd0:    depth_of = 4'd8;
      2'd1:    depth_of = 4'd4;
      2'd2:    depth_of = 4'd4;
      default: depth_of = 4'd1;
    endcase
  endfunction

  function automatic logic [2:0] ptr_inc(input logic [2:0] p, input logic [1:0] n);
    logic [3:0] nx;
    nx = {1'b0, p} + 4'd1;
    ptr_inc = (nx == depth_of(n)) ? 3'd0 : nx[2:0];
  endfunction

  function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    for (int b = 0; b < 4; b++) begin
      byte_merge[b*8 +: 8] = sel[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
    end
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      lane_mask[b*8 +: 8] = {8{sel[b]}};
    end
  endfunction

  // Smallest divisor keeping the converter clock at or below the upper limit.
  function automatic logic [3:0] div_for(input logic [7:0] mhz);
    div_for = 4'd15;
    for (int d = 15; d >= 1; d--) begin
      if (int'(mhz) * 1000 <= d * CONV_CLK_MAX_KHZ) begin
        div_for = d[3:0];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [3:0]            enable_reg;
  logic [3:0]            mask_reg;
  logic [15:0]           trig_sel_reg;
  logic [15:0]           priority_reg;
  logic [2:0]            avg_reg;
  logic [31:0]           input_reg [NUM_SEQ];
  logic [31:0]           flags_reg [NUM_SEQ];
  logic [3:0]            raw_int_reg;
  logic [3:0]            ovf_reg;
  logic [3:0]            unf_reg;
  logic [3:0]            pend_reg;
  logic [RESULT_W-1:0]   fifo_mem [NUM_SEQ][MAX_DEPTH];
  logic [2:0]            head_reg [NUM_SEQ];
  logic [2:0]            tail_reg [NUM_SEQ];
  logic [3:0]            count_reg [NUM_SEQ];
  seq_state_t            state_reg;
  logic [1:0]            active_reg;
  logic [2:0]            step_reg;
  logic [6:0]            avg_cnt_reg;
  logic [ACC_W-1:0]      acc_reg;
  logic [31:0]           rdata_next;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic       bus_req;
  logic       bus_take;
  logic       in_seq;
  logic [1:0] seq_idx;
  logic [4:0] seq_sub;
  logic [2:0] blk;

  assign bus_req  = wb_cyc_i & wb_stb_i;
  assign bus_take = bus_req & wb_ack_o;
  assign blk      = wb_adr_i[7:5];
  assign in_seq   = (wb_adr_i[11:8] == 4'h0) && (blk >= SEQ_BLK_LO) && (blk <= SEQ_BLK_HI);
  assign seq_idx  = 2'(blk - SEQ_BLK_LO);
  assign seq_sub  = wb_adr_i[4:0];

  // Answer comes one cycle after the request is seen; effects happen at the ack edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req & ~wb_ack_o & ~wb_we_i) begin
      wb_dat_o <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Converter datapath and averaging
  // ----------------------------------------------------------------
  logic              conv_fin;
  logic              avg_last;
  logic              push;
  logic [ACC_W-1:0]  acc_sum;
  logic [RESULT_W-1:0] push_data;
  logic [3:0]        cur_flags;
  logic [3:0]        cur_input;
  logic              seq_end;

  assign conv_fin  = (state_reg == ST_WAIT) && conv_done_i;
  assign acc_sum   = acc_reg + {{(ACC_W-RESULT_W){1'b0}}, conv_data_i};
  assign avg_last  = (avg_cnt_reg == 7'((7'd1 << avg_reg) - 7'd1));
  assign push_data = (avg_reg == 3'd0) ? conv_data_i : RESULT_W'(acc_sum >> avg_reg);
  assign push      = conv_fin && avg_last && enable_reg[active_reg];
  assign cur_flags = flags_reg[active_reg][step_reg*4 +: 4];
  assign cur_input = input_reg[active_reg][step_reg*4 +: 4];
  assign seq_end   = cur_flags[FLAG_END] || ({1'b0, step_reg} == depth_of(active_reg) - 4'd1);

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  logic       grant_valid;
  logic [1:0] grant_idx;

  always_comb begin
    logic [1:0] best;
    best        = 2'd3;
    grant_valid = 1'b0;
    grant_idx   = 2'd0;
    for (int n = 0; n < NUM_SEQ; n++) begin
      if (enable_reg[n] && pend_reg[n] &&
          (!grant_valid || priority_reg[n*4 +: 2] < best)) begin
        grant_valid = 1'b1;
        grant_idx   = 2'(n);
        best        = priority_reg[n*4 +: 2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer control
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg    <= ST_IDLE;
      active_reg   <= 2'd0;
      step_reg     <= 3'd0;
      avg_cnt_reg  <= 7'd0;
      acc_reg      <= '0;
      conv_start_o <= 1'b0;
      conv_cmd_o   <= '0;
    end else begin
      conv_start_o <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (grant_valid) begin
            active_reg  <= grant_idx;
            step_reg    <= 3'd0;
            avg_cnt_reg <= 7'd0;
            acc_reg     <= '0;
            state_reg   <= ST_CONV;
          end
        end
        ST_CONV: begin
          conv_start_o         <= 1'b1;
          conv_cmd_o.input_sel <= cur_input;
          conv_cmd_o.diff      <= cur_flags[FLAG_DIFF];
          conv_cmd_o.temp      <= cur_flags[FLAG_TEMP];
          state_reg            <= ST_WAIT;
        end
        ST_WAIT: begin
          if (conv_done_i) begin
            if (!enable_reg[active_reg]) begin
              state_reg <= ST_IDLE;
            end else if (!avg_last) begin
              avg_cnt_reg <= avg_cnt_reg + 7'd1;
              acc_reg     <= acc_sum;
              state_reg   <= ST_CONV;
            end else begin
              avg_cnt_reg <= 7'd0;
              acc_reg     <= '0;
              if (seq_end) begin
                state_reg <= ST_IDLE;
              end else begin
                step_reg  <= step_reg + 3'd1;
                state_reg <= ST_CONV;
              end
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Trigger capture
  // ----------------------------------------------------------------
  logic [3:0] trig_hit;

  always_comb begin
    for (int n = 0; n < NUM_SEQ; n++) begin
      unique case (trig_sel_reg[n*4 +: 4])
        TRIG_SOFTWARE: trig_hit[n] = bus_take && wb_we_i && (wb_adr_i == OFF_SW_START) &&
                                     wb_sel_i[0] && wb_dat_i[n];
        TRIG_COMPARE:  trig_hit[n] = trig_comp_i;
        TRIG_TIMER:    trig_hit[n] = trig_timer_i;
        TRIG_PWM:      trig_hit[n] = trig_pwm_i;
        TRIG_GPIO:     trig_hit[n] = trig_gpio_i;
        TRIG_ALWAYS:   trig_hit[n] = 1'b1;
        default:       trig_hit[n] = 1'b0;
      endcase
    end
  end

  // A trigger that lands while its sequence runs is kept, so the sequence repeats once.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_reg <= 4'h0;
    end else begin
      for (int n = 0; n < NUM_SEQ; n++) begin
        if (trig_hit[n] && enable_reg[n]) begin
          pend_reg[n] <= 1'b1;
        end else if (!enable_reg[n] ||
                     (state_reg == ST_IDLE && grant_valid && grant_idx == 2'(n))) begin
          pend_reg[n] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_reg   <= 4'h0;
      mask_reg     <= 4'h0;
      trig_sel_reg <= 16'h0000;
      priority_reg <= PRIORITY_RST;
      avg_reg      <= AVG_RST;
      for (int n = 0; n < NUM_SEQ; n++) begin
        input_reg[n] <= 32'h0000_0000;
        flags_reg[n] <= 32'h0000_0000;
      end
    end else if (bus_take && wb_we_i) begin
      if (wb_adr_i == OFF_ENABLE && wb_sel_i[0]) begin
        enable_reg <= wb_dat_i[3:0];
      end
      if (wb_adr_i == OFF_INT_MASK && wb_sel_i[0]) begin
        mask_reg <= wb_dat_i[3:0];
      end
      if (wb_adr_i == OFF_TRIG_SEL) begin
        trig_sel_reg <= 16'(byte_merge({16'h0000, trig_sel_reg}, wb_dat_i, wb_sel_i));
      end
      if (wb_adr_i == OFF_PRIORITY) begin
        priority_reg <= 16'(byte_merge({16'h0000, priority_reg}, wb_dat_i, wb_sel_i))
                        & 16'h3333;
      end
      if (wb_adr_i == OFF_AVG_CTRL && wb_sel_i[0]) begin
        avg_reg <= (wb_dat_i[2:0] > 3'(AVG_MAX_LOG2)) ? 3'(AVG_MAX_LOG2) : wb_dat_i[2:0];
      end
      if (in_seq && seq_sub == SUB_INPUT) begin
        input_reg[seq_idx] <= byte_merge(input_reg[seq_idx], wb_dat_i, wb_sel_i)
                              & (32'hffff_ffff >> (32 - 4 * int'(depth_of(seq_idx))));
      end
      if (in_seq && seq_sub == SUB_FLAGS) begin
        flags_reg[seq_idx] <= byte_merge(flags_reg[seq_idx], wb_dat_i, wb_sel_i)
                              & (32'hffff_ffff >> (32 - 4 * int'(depth_of(seq_idx))));
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  logic [3:0] isc_clr;
  logic [3:0] ovf_clr;
  logic [3:0] unf_clr;
  logic [3:0] ovf_set;
  logic [3:0] unf_set;
  logic [3:0] ris_set;
  logic       pop_req;
  logic [31:0] lanes;

  assign pop_req = bus_take && !wb_we_i && in_seq && seq_sub == SUB_FIFO;
  assign lanes   = lane_mask(wb_sel_i);

  always_comb begin
    for (int n = 0; n < NUM_SEQ; n++) begin
      ris_set[n] = push && active_reg == 2'(n) && cur_flags[FLAG_IE];
      ovf_set[n] = push && active_reg == 2'(n) && count_reg[n] == depth_of(2'(n));
      unf_set[n] = pop_req && seq_idx == 2'(n) && count_reg[n] == 4'd0;
    end
  end

  assign isc_clr = (bus_take && wb_we_i && wb_adr_i == OFF_MASK_CLR) ?
                   (wb_dat_i[3:0] & lanes[3:0]) : 4'h0;
  assign ovf_clr = (bus_take && wb_we_i && wb_adr_i == OFF_OVERFLOW) ?
                   (wb_dat_i[3:0] & lanes[3:0]) : 4'h0;
  assign unf_clr = (bus_take && wb_we_i && wb_adr_i == OFF_UNDERFLW) ?
                   (wb_dat_i[3:0] & lanes[3:0]) : 4'h0;

  // A new event in the clearing cycle survives the clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      raw_int_reg <= 4'h0;
      ovf_reg     <= 4'h0;
      unf_reg     <= 4'h0;
    end else begin
      raw_int_reg <= (raw_int_reg & ~isc_clr) | ris_set;
      ovf_reg     <= (ovf_reg & ~ovf_clr) | ovf_set;
      unf_reg     <= (unf_reg & ~unf_clr) | unf_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 4'h0;
    end else begin
      irq_o <= ((raw_int_reg & ~isc_clr) | ris_set) & mask_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_div_o <= 4'd1;
    end else begin
      conv_div_o <= div_for(src_mhz_i);
    end
  end

  // ----------------------------------------------------------------
  // Result FIFOs
  // ----------------------------------------------------------------
  // circular buffers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int n = 0; n < NUM_SEQ; n++) begin
        head_reg[n]  <= 3'd0;
        tail_reg[n]  <= 3'd0;
        count_reg[n] <= 4'd0;
      end
    end else begin
      for (int n = 0; n < NUM_SEQ; n++) begin
        logic do_push;
        logic do_pop;
        do_push = push && active_reg == 2'(n) && count_reg[n] != depth_of(2'(n));
        do_pop  = pop_req && seq_idx == 2'(n) && count_reg[n] != 4'd0;
        if (do_push) begin
          fifo_mem[n][head_reg[n]] <= push_data;
          head_reg[n]              <= ptr_inc(head_reg[n], 2'(n));
        end
        if (do_pop) begin
          tail_reg[n] <= ptr_inc(tail_reg[n], 2'(n));
        end
        count_reg[n] <= count_reg[n] + {3'd0, do_push} - {3'd0, do_pop};
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (wb_adr_i)
      OFF_ENABLE:   rdata_next = {28'h0, enable_reg};
      OFF_RAW_INT:  rdata_next = {28'h0, raw_int_reg};
      OFF_INT_MASK: rdata_next = {28'h0, mask_reg};
      OFF_MASK_CLR: rdata_next = {28'h0, raw_int_reg & mask_reg};
      OFF_OVERFLOW: rdata_next = {28'h0, ovf_reg};
      OFF_TRIG_SEL: rdata_next = {16'h0, trig_sel_reg};
      OFF_UNDERFLW: rdata_next = {28'h0, unf_reg};
      OFF_PRIORITY: rdata_next = {16'h0, priority_reg};
      OFF_AVG_CTRL: rdata_next = {29'h0, avg_reg};
      default: begin
        if (in_seq) begin
          unique case (seq_sub)
            SUB_INPUT:  rdata_next = input_reg[seq_idx];
            SUB_FLAGS:  rdata_next = flags_reg[seq_idx];
            SUB_FIFO:   rdata_next = {22'h0, fifo_mem[seq_idx][tail_reg[seq_idx]]};
            SUB_STATUS: begin
              rdata_next[FST_TAIL +: 3] = tail_reg[seq_idx];
              rdata_next[FST_HEAD +: 3] = head_reg[seq_idx];
              rdata_next[FST_EMPTY]     = count_reg[seq_idx] == 4'd0;
              rdata_next[FST_FULL]      = count_reg[seq_idx] == depth_of(seq_idx);
            end
            default:    rdata_next = 32'h0000_0000;
          endcase
        end
      end
    endcase
  end

endmodule

// File: sim/seq_ctrl_props.sv
// Checker for seq_ctrl, watching only the top ports.
// Assumes one clock domain with the synchronous reset rst_i.
`timescale 1ns/1ps
module seq_ctrl_props (
  input wire logic               clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire logic               conv_start_o, conv_done_i,
  input wire logic [7:0]         src_mhz_i,
  input wire logic [3:0]         conv_div_o, irq_o,
  input seq_ctrl_pkg::conv_cmd_t conv_cmd_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("register access not answered in one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without a request");
  start_gap_a: assert property (conv_start_o |=> !conv_start_o [*2])
    else $error("conversion starts too close together");
  done_gap_a: assert property (conv_done_i |=> !conv_start_o)
    else $error("next step started too soon after done");
  cmd_hold_a: assert property (!conv_start_o |-> $stable(conv_cmd_o))
    else $error("conversion command changed without a start");
  // An interrupt may only appear after a done one cycle back or a register write two cycles back.
  irq_rise_a: assert property ((irq_o & ~$past(irq_o)) != 4'h0 |->
    $past(conv_done_i) || ($past(wb_ack_o, 2) && $past(wb_we_i, 2)))
    else $error("interrupt rose without a cause");
  irq_fall_a: assert property ((~irq_o & $past(irq_o)) != 4'h0 |->
    ($past(wb_ack_o) && $past(wb_we_i)) || ($past(wb_ack_o, 2) && $past(wb_we_i, 2)))
    else $error("interrupt fell without a write");
  div_match_a: assert property ($stable(src_mhz_i) && !$past(rst_i) |->
    32'(src_mhz_i) * 1000 <= 32'(conv_div_o) * 18000 &&
    32'(src_mhz_i) * 1000 > (32'(conv_div_o) - 1) * 18000)
    else $error("converter divider is not the smallest fitting value");
endmodule
bind seq_ctrl seq_ctrl_props chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .conv_start_o(conv_start_o),
  .conv_done_i(conv_done_i), .src_mhz_i(src_mhz_i), .conv_div_o(conv_div_o),
  .irq_o(irq_o), .conv_cmd_o(conv_cmd_o));

// File: sim/conv_core_model.sv
// Behavioural converter core answering each start with one done pulse.
// Assumes starts are single-cycle pulses; lat_i sets the answer delay.
`timescale 1ns/1ps
module conv_core_model (
  input  wire logic               clk_i,
  input  wire logic               start_i,
  input  seq_ctrl_pkg::conv_cmd_t cmd_i,
  input  wire logic [3:0]         lat_i,
  output logic                    done_o,
  output logic [9:0]              data_o
);
  import seq_ctrl_pkg::*;
  logic [4:0] cnt_reg  = 5'h0;
  logic [9:0] res_reg  = 10'h0;
  logic [9:0] dat_reg  = 10'h155;
  logic       done_reg = 1'b0;
  assign done_o = done_reg;
  assign data_o = dat_reg;
  // The data line toggles outside done so a stale value is never mistaken for a result.
  always_ff @(posedge clk_i) begin
    done_reg <= (cnt_reg == 5'h1);
    dat_reg  <= (cnt_reg == 5'h1) ? res_reg : ~dat_reg;
    if (start_i) begin
      cnt_reg <= 5'(lat_i) + 5'h1;
      res_reg <= {2'b10, cmd_i.input_sel, cmd_i.temp, cmd_i.diff, 2'b01};
    end else if (cnt_reg != 5'h0) begin
      cnt_reg <= cnt_reg - 5'h1;
    end
  end
endmodule

// File: sim/tb_seq_ctrl.sv
// Self-checking bench for seq_ctrl with a converter core model.
// Assumes each Wishbone access is answered by a one-cycle ack.
`timescale 1ns/1ps
module tb_seq_ctrl;
  import seq_ctrl_pkg::*;
  logic clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, trig = 0;
  logic [11:0] wb_adr_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, rd = 0;
  logic [3:0]  wb_sel_i = 0, conv_div_o, irq_o, lat = 4'h3;
  logic [7:0]  src = 8'h32;
  logic        wb_ack_o, conv_start_o, conv_done_i;
  logic [9:0]  conv_data_i;
  conv_cmd_t   conv_cmd_o;
  int err_total = 0, num_checks = 0;
  seq_ctrl dut_u (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
    .wb_stb_i, .wb_dat_o, .wb_ack_o, .trig_timer_i(trig), .trig_comp_i(trig),
    .trig_pwm_i(trig), .trig_gpio_i(trig), .conv_start_o, .conv_cmd_o, .conv_done_i,
    .conv_data_i, .src_mhz_i(src), .conv_div_o, .irq_o);
  conv_core_model core_u (.clk_i, .start_i(conv_start_o), .cmd_i(conv_cmd_o), .lat_i(lat),
    .done_o(conv_done_i), .data_o(conv_data_i));
  initial forever #20 clk_i = ~clk_i;
  task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wb(logic we, logic [11:0] a, logic [31:0] d);
    int t = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, 4'hf};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++t < 50);
    if (wb_ack_o !== 1'b1) err_total++;
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask
  task automatic s_reset;
    wb(0, OFF_PRIORITY, 0);
    chk("priority", rd, 32'h3210);
    wb(0, OFF_AVG_CTRL, 0);
    chk("averaging", rd, 0);
    wb(0, 12'h3fc, 0);
    chk("unmapped", rd, 0);
    chk("divider", 32'(conv_div_o), 32'h3);
    src <= 8'h10;
    repeat (3) @(posedge clk_i);
    chk("divider low", 32'(conv_div_o), 32'h1);
  endtask
  task automatic s_seq;
    logic [3:0] ins [3] = '{4'h1, 4'h3, 4'h3};
    wb(1, OFF_SEQ_BASE, 32'h5331);
    wb(1, OFF_SEQ_BASE + 12'h4, 32'h4640);
    wb(1, OFF_INT_MASK, 1);
    wb(1, OFF_ENABLE, 1);
    wb(1, OFF_SW_START, 1);
    for (int i = 0; i < 200 && rd[6:4] !== 3'h3; i++) wb(0, OFF_SEQ_BASE + 12'hc, 0);
    repeat (30) @(posedge clk_i);
    wb(0, OFF_SEQ_BASE + 12'hc, 0);
    chk("status", rd, 32'h30);
    wb(0, OFF_RAW_INT, 0);
    chk("raw", rd, 1);
    chk("irq", 32'(irq_o), 1);
    foreach (ins[i]) begin
      wb(0, OFF_SEQ_BASE + 12'h8, 0);
      chk("result", rd, {22'h0, 2'b10, ins[i], 4'h1});
    end
    wb(0, OFF_SEQ_BASE + 12'hc, 0);
    chk("drained", rd, 32'h133);
    wb(0, OFF_SEQ_BASE + 12'h8, 0);
    wb(0, OFF_UNDERFLW, 0);
    chk("underflow", rd, 1);
    wb(1, OFF_MASK_CLR, 0);
    wb(0, OFF_MASK_CLR, 0);
    chk("masked", rd, 1);
    wb(1, OFF_MASK_CLR, 1);
    wb(0, OFF_RAW_INT, 0);
    chk("cleared", rd, 0);
    chk("irq off", 32'(irq_o), 0);
  endtask
  task automatic s_pri;
    lat <= 4'h9;
    wb(1, OFF_SEQ_BASE, 2);
    wb(1, OFF_SEQ_BASE + 12'h4, 2);
    wb(1, OFF_SEQ_BASE + 12'h60, 7);
    wb(1, OFF_SEQ_BASE + 12'h64, 2);
    wb(1, OFF_PRIORITY, 32'h0123);
    wb(1, OFF_ENABLE, 32'h9);
    wb(1, OFF_SW_START, 32'h9);
    for (int i = 0; i < 20 && conv_start_o !== 1'b1; i++) @(posedge clk_i);
    chk("first input", 32'(conv_cmd_o.input_sel), 7);
    repeat (60) @(posedge clk_i);
    wb(1, OFF_SW_START, 32'h8);
    repeat (40) @(posedge clk_i);
    wb(0, OFF_OVERFLOW, 0);
    chk("overflow", rd, 32'h8);
  endtask
  task automatic s_trig;
    wb(1, 12'h060, 5);
    wb(1, 12'h064, 6);
    wb(1, OFF_TRIG_SEL, 32'h20);
    wb(1, OFF_AVG_CTRL, 2);
    wb(1, OFF_ENABLE, 2);
    trig <= 1;
    @(posedge clk_i);
    trig <= 0;
    repeat (100) @(posedge clk_i);
    wb(0, 12'h06c, 0);
    chk("avg status", rd, 32'h10);
    wb(0, 12'h068, 0);
    chk("avg result", rd, {22'h0, 2'b10, 4'h5, 4'h1});
    wb(0, OFF_RAW_INT, 0);
    chk("raw unmasked", rd, 2);
    chk("irq masked", 32'(irq_o), 0);
    wb(1, OFF_AVG_CTRL, 0);
    wb(1, OFF_TRIG_SEL, 32'h50);
    repeat (120) @(posedge clk_i);
    wb(0, 12'h06c, 0);
    chk("always full", 32'(rd[12]), 1);
  endtask
  task automatic final_report;
    if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    s_reset;
    s_seq;
    s_pri;
    s_trig;
    final_report;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    final_report;
  end
endmodule
